// ---- design/wesr_defs.svh ----
// Constants of the wiper store/restore sequencer: timing, reset values, address base.
// Assumes the including file is compiled with the package wesr_pkg.
`ifndef WESR_DEFS_SVH
`define WESR_DEFS_SVH

// Core clock rate in hertz
`define WESR_CLK_HZ       100_000_000
// Store time in milliseconds, restore and rewrite times in microseconds
`define WESR_T_STORE_MS   26
`define WESR_T_RESTORE_US 300
`define WESR_T_REWRITE_US 540
// Cycle counts derived from the times (typical figures, taken exactly)
`define WESR_STORE_CYC    ((`WESR_CLK_HZ / 1000) * `WESR_T_STORE_MS)
`define WESR_RESTORE_CYC  ((`WESR_CLK_HZ / 1_000_000) * `WESR_T_RESTORE_US)
`define WESR_REWRITE_CYC  ((`WESR_CLK_HZ / 1_000_000) * `WESR_T_REWRITE_US)
// Midscale wiper code, also the factory content of the nonvolatile store
`define WESR_MIDSCALE     8'h80
// Upper five bits of the bus address; value is arbitrary
`define WESR_ADDR_BASE    5'h0c
// Cycles after reset release before the address pins are trusted
`define WESR_SYNC_SETTLE  2'h2

`endif

// ---- design/wesr_dummy_unused.sv ----
// Holds no logic; the block lives in the other design files.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- design/wesr_nv_if.sv ----
// Link between the sequencer and its nonvolatile store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface wesr_nv_if;
  logic       start_store;   // Pulse: copy store_data into the store
  logic       start_restore; // Pulse: read the store out
  logic [7:0] store_data;    // Data to be stored
  logic       busy;          // Operation in progress
  logic       done;          // Pulse: operation finished
  logic [7:0] load_data;     // Stored code, valid with done

  modport ctrl (output start_store, start_restore, store_data,
                input  busy, done, load_data);
  modport mem  (input  start_store, start_restore, store_data,
                output busy, done, load_data);
endinterface
`default_nettype wire

// ---- design/wesr_nvmem.sv ----
// Nonvolatile wiper store with its store and restore durations.
// Assumes starts arrive only while not busy; a start while busy is ignored.
// Flip-flops cannot outlive power loss, so reset loads the factory code.
`timescale 1ns/1ps
`default_nettype none
`include "wesr_defs.svh"
module wesr_nvmem #(
  parameter int STORE_CYC   = `WESR_STORE_CYC,
  parameter int RESTORE_CYC = `WESR_RESTORE_CYC
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Sequencer side
  wesr_nv_if.mem    nv
);
  localparam int CW = $clog2(STORE_CYC + 1);

  logic [7:0]    cell_reg;   // Stored wiper code
  logic [CW-1:0] cnt_reg;    // Remaining cycles of the operation
  logic          busy_reg;   // Operation running
  logic          is_st_reg;  // Running operation is a store
  logic          done_reg;   // Completion pulse
  logic [7:0]    pend_reg;   // Data waiting to be committed

  // Operation timer; data commits only at the end of a store
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_reg  <= 1'b0;
      is_st_reg <= 1'b0;
      cnt_reg   <= '0;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (!busy_reg) begin
        if (nv.start_store) begin
          busy_reg  <= 1'b1;
          is_st_reg <= 1'b1;
          cnt_reg   <= CW'(STORE_CYC - 1);
        end else if (nv.start_restore) begin
          busy_reg  <= 1'b1;
          is_st_reg <= 1'b0;
          cnt_reg   <= CW'(RESTORE_CYC - 1);
        end
      end else if (cnt_reg == '0) begin
        busy_reg <= 1'b0;
        done_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // Factory content is midscale; store data latched at start
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cell_reg <= `WESR_MIDSCALE;
      pend_reg <= `WESR_MIDSCALE;
    end else begin
      if (!busy_reg && nv.start_store) begin
        pend_reg <= nv.store_data;
      end
      if (busy_reg && is_st_reg && cnt_reg == '0) begin
        cell_reg <= pend_reg;
      end
    end
  end

  assign nv.busy      = busy_reg;
  assign nv.done      = done_reg;
  assign nv.load_data = cell_reg;
endmodule
`default_nettype wire

// ---- design/wesr_pkg.sv ----
// Types shared by the wiper store/restore sequencer modules.
// Assumes nothing of its surroundings.
package wesr_pkg;

  // Commands handed over by the bus front end
  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_WR_WIPER,
    CMD_WR_NV,
    CMD_STORE,
    CMD_RESTORE,
    CMD_WP
  } wesr_cmd_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_PRESET,
    ST_POR_RESTORE,
    ST_IDLE,
    ST_STORE,
    ST_RESTORE
  } wesr_state_t;

endpackage

// ---- design/wesr_top.sv ----
// Wiper preset, power-on reload, store/restore sequencing, address latch.
// Assumes a bus front end hands over decoded commands on this clock and
// that SCL, SDA and the address pins are asynchronous pins.
//
// What this block does
// - Preset wiper midscale, then reload from store
// - Power-on reload takes typically 300 us
// - Restore command reloads wiper in 300 us
// - Store of wiper takes typically 26 ms
// - Address pins sampled once after power-up
// - Serial data captured on SCL rising edge
// - Store leaves factory holding midscale code
// - Wiper code is 8 bits, 256 taps
// - Address pins decode into 7-bit bus address
// - Write protect follows data LSB, stores nothing
`timescale 1ns/1ps
`default_nettype none
`include "wesr_defs.svh"
module wesr_top #(
  parameter int STORE_CYC   = `WESR_STORE_CYC,
  parameter int RESTORE_CYC = `WESR_RESTORE_CYC,
  parameter int REWRITE_CYC = `WESR_REWRITE_CYC
) (
  // Clock and power-on reset
  input  wire logic                i_clk,
  input  wire logic                i_resetn,
  // Serial pins
  input  wire logic                i_scl,
  input  wire logic                i_sda,
  // Address select pins
  input  wire logic                i_addr_sel_0,
  input  wire logic                i_addr_sel_1,
  // Command from the bus front end
  input  wire logic                i_cmd_valid,
  input  wire wesr_pkg::wesr_cmd_t i_cmd,
  input  wire logic [7:0]          i_cmd_data,
  // Wiper and status
  output logic [7:0]               o_wiper_code,
  output logic                     o_busy,
  output logic                     o_store_busy,
  output logic                     o_nv_write_ready,
  output logic                     o_write_protect,
  output logic                     o_cmd_refused,
  output logic                     o_bus_during_store,
  // Address and serial capture
  output logic [6:0]               o_bus_addr,
  output logic                     o_addr_valid,
  output logic [7:0]               o_rx_shift,
  output logic                     o_rx_bit
);
  localparam int RW = $clog2(REWRITE_CYC + 1);

  wesr_nv_if nv ();

  logic [3:0]            sync1_reg;      // First stage, read only by sync2_reg
  logic [3:0]            sync2_reg;      // Stable copies: scl, sda, sel0, sel1
  logic                  scl_prev_reg;   // Last stable SCL level
  wesr_pkg::wesr_state_t state_reg;      // Sequencer state
  logic [7:0]            wiper_code_register_reg; // Wiper code
  logic                  wp_reg;         // Write protect
  logic                  refused_reg;    // Refused command pulse
  logic                  st_req_reg;     // Store start pulse
  logic                  rs_req_reg;     // Restore start pulse
  logic [7:0]            st_data_reg;    // Data to be stored
  logic [RW-1:0]         rewrite_cnt_reg; // Wait before nonvolatile writes
  logic                  nv_ready_reg;   // Nonvolatile write allowed
  logic [1:0]            settle_reg;     // Pin synchroniser settling
  logic                  addr_valid_reg; // Address latched
  logic [6:0]            addr_reg;       // Latched bus address
  logic [7:0]            rx_shift_reg;   // Captured serial bits
  logic                  rx_bit_reg;     // Bit capture pulse
  logic                  violate_reg;    // Sticky: SCL activity during store
  logic                  scl_rise;       // SCL rising edge
  logic                  accept;         // Command taken this cycle
  logic                  busy_reg;       // Sequencer away from idle
  logic                  store_busy_reg; // Store in progress

  // Decide whether a command may be taken in the current state
  function automatic logic cmd_allowed(input wesr_pkg::wesr_cmd_t c, input logic wp,
                                       input logic ready);
    logic ok;
    ok = 1'b1;
    if (wp && (c == wesr_pkg::CMD_WR_WIPER || c == wesr_pkg::CMD_WR_NV ||
               c == wesr_pkg::CMD_STORE)) begin
      ok = 1'b0;
    end
    if (!ready && (c == wesr_pkg::CMD_WR_NV || c == wesr_pkg::CMD_STORE)) begin
      ok = 1'b0;
    end
    return ok;
  endfunction

  // Two-stage synchronisers for all asynchronous pins
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      // Serial lines reset to their idle high level: no false SCL edge
      sync1_reg    <= 4'h3;
      sync2_reg    <= 4'h3;
      scl_prev_reg <= 1'b1;
    end else begin
      sync1_reg    <= {i_addr_sel_1, i_addr_sel_0, i_sda, i_scl};
      sync2_reg    <= sync1_reg;
      scl_prev_reg <= sync2_reg[0];
    end
  end

  assign scl_rise = sync2_reg[0] && !scl_prev_reg;
  assign accept   = i_cmd_valid && (state_reg == wesr_pkg::ST_IDLE) &&
                    cmd_allowed(i_cmd, wp_reg, nv_ready_reg);

  // Serial bits shift in on rising SCL only
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_shift_reg <= 8'h00;
      rx_bit_reg   <= 1'b0;
    end else begin
      rx_bit_reg <= scl_rise;
      if (scl_rise) begin
        rx_shift_reg <= {rx_shift_reg[6:0], sync2_reg[1]};
      end
    end
  end

  // Bus activity during a store is flagged; it may be lost downstream
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      violate_reg <= 1'b0;
    end else if (scl_rise && state_reg == wesr_pkg::ST_STORE) begin
      violate_reg <= 1'b1;
    end
  end

  // Address pins are caught once, after the synchroniser has filled
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      settle_reg     <= 2'h0;
      addr_valid_reg <= 1'b0;
      addr_reg       <= {`WESR_ADDR_BASE, 2'h0};
    end else if (!addr_valid_reg) begin
      if (settle_reg == `WESR_SYNC_SETTLE) begin
        addr_valid_reg <= 1'b1;
        addr_reg       <= {`WESR_ADDR_BASE, sync2_reg[3], sync2_reg[2]};
      end else begin
        settle_reg <= settle_reg + 2'h1;
      end
    end
  end

  // Wait after the power-on preset before nonvolatile writes
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rewrite_cnt_reg <= '0;
      nv_ready_reg    <= 1'b0;
    end else if (!nv_ready_reg) begin
      if (rewrite_cnt_reg == RW'(REWRITE_CYC - 1)) begin
        nv_ready_reg <= 1'b1;
      end else begin
        rewrite_cnt_reg <= rewrite_cnt_reg + 1'b1;
      end
    end
  end

  // Sequencer: preset, power-on reload, then command handling
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg   <= wesr_pkg::ST_PRESET;
      busy_reg    <= 1'b1;
      store_busy_reg <= 1'b0;
      st_req_reg  <= 1'b0;
      rs_req_reg  <= 1'b0;
      st_data_reg <= `WESR_MIDSCALE;
    end else begin
      st_req_reg <= 1'b0;
      rs_req_reg <= 1'b0;
      unique case (state_reg)
        wesr_pkg::ST_PRESET: begin
          rs_req_reg <= 1'b1;
          state_reg  <= wesr_pkg::ST_POR_RESTORE;
        end
        wesr_pkg::ST_POR_RESTORE: begin
          if (nv.done) begin
            state_reg <= wesr_pkg::ST_IDLE;
            busy_reg  <= 1'b0;
          end
        end
        wesr_pkg::ST_IDLE: begin
          if (accept) begin
            unique case (i_cmd)
              wesr_pkg::CMD_STORE: begin
                st_req_reg  <= 1'b1;
                st_data_reg <= wiper_code_register_reg;
                state_reg   <= wesr_pkg::ST_STORE;
                busy_reg    <= 1'b1;
                store_busy_reg <= 1'b1;
              end
              wesr_pkg::CMD_WR_NV: begin
                st_req_reg  <= 1'b1;
                st_data_reg <= i_cmd_data;
                state_reg   <= wesr_pkg::ST_STORE;
                busy_reg    <= 1'b1;
                store_busy_reg <= 1'b1;
              end
              wesr_pkg::CMD_RESTORE: begin
                rs_req_reg <= 1'b1;
                state_reg  <= wesr_pkg::ST_RESTORE;
                busy_reg   <= 1'b1;
              end
              default: begin
                state_reg <= wesr_pkg::ST_IDLE;
              end
            endcase
          end
        end
        wesr_pkg::ST_STORE: begin
          if (nv.done) begin
            state_reg <= wesr_pkg::ST_IDLE;
            busy_reg  <= 1'b0;
            store_busy_reg <= 1'b0;
          end
        end
        wesr_pkg::ST_RESTORE: begin
          if (nv.done) begin
            state_reg <= wesr_pkg::ST_IDLE;
            busy_reg  <= 1'b0;
          end
        end
      endcase
    end
  end

  // Wiper: midscale at reset, one-step update when a reload finishes
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wiper_code_register_reg <= `WESR_MIDSCALE;
    end else if (nv.done && (state_reg == wesr_pkg::ST_POR_RESTORE ||
                             state_reg == wesr_pkg::ST_RESTORE)) begin
      wiper_code_register_reg <= nv.load_data;
    end else if (accept && i_cmd == wesr_pkg::CMD_WR_WIPER) begin
      wiper_code_register_reg <= i_cmd_data;
    end
  end

  // Write protect takes the LSB only; no data is stored
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wp_reg <= 1'b0;
    end else if (accept && i_cmd == wesr_pkg::CMD_WP) begin
      wp_reg <= i_cmd_data[0];
    end
  end

  // Refusal pulse: busy, protected or too early
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      refused_reg <= 1'b0;
    end else begin
      refused_reg <= i_cmd_valid && !accept && (i_cmd != wesr_pkg::CMD_NOP);
    end
  end

  wesr_nvmem #(
    .STORE_CYC   (STORE_CYC),
    .RESTORE_CYC (RESTORE_CYC)
  ) u_nvmem (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .nv       (nv)
  );

  assign nv.start_store   = st_req_reg;
  assign nv.start_restore = rs_req_reg;
  assign nv.store_data    = st_data_reg;

  // Outputs straight from flip-flops
  assign o_wiper_code       = wiper_code_register_reg;
  assign o_busy             = busy_reg;
  assign o_store_busy       = store_busy_reg;
  assign o_nv_write_ready   = nv_ready_reg;
  assign o_write_protect    = wp_reg;
  assign o_cmd_refused      = refused_reg;
  assign o_bus_during_store = violate_reg;
  assign o_bus_addr         = addr_reg;
  assign o_addr_valid       = addr_valid_reg;
  assign o_rx_shift         = rx_shift_reg;
  assign o_rx_bit           = rx_bit_reg;
endmodule
`default_nettype wire

// ---- verif/wesr_i2c_model.sv ----
// Bus controller model driving the serial clock and data pins.
// Assumes pull-ups: both lines rest high, clock still between frames.
`timescale 1ns/1ps
`default_nettype none
module wesr_i2c_model (
  // Serial pins toward the device
  output var logic o_scl,
  output var logic o_sda
);
  // Released lines sit at the pull-up level
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // One byte, newest bit last, 125 ns clock period
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      o_scl = 1'b0;
      #31.25 o_sda = b[i];
      #31.25 o_scl = 1'b1;
      #62.5;
    end
    o_sda = 1'b1; // Back to pull-up level
  endtask
endmodule
`default_nettype wire

// ---- verif/wesr_monitor.sv ----
// Checker on the ports of the wiper sequencer top.
// Assumes the short test timings of the bench (store 20, restore 10).
`timescale 1ns/1ps
`default_nettype none
`include "wesr_defs.svh"
module wesr_monitor (
  // Clock, reset and commands
  input wire logic                i_clk,
  input wire logic                i_resetn,
  input wire logic                i_cmd_valid,
  input wire wesr_pkg::wesr_cmd_t i_cmd,
  input wire logic [7:0]          i_cmd_data,
  // Observed outputs
  input wire logic [7:0]          o_wiper_code,
  input wire logic                o_busy,
  input wire logic                o_store_busy,
  input wire logic                o_nv_write_ready,
  input wire logic                o_write_protect,
  input wire logic                o_cmd_refused,
  input wire logic [6:0]          o_bus_addr,
  input wire logic                o_addr_valid,
  input wire logic [7:0]          o_rx_shift,
  input wire logic                o_rx_bit
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic       take;    // Command offered while idle
  logic       wp_bit;  // Protect request bit
  logic [7:0] rx_prev; // Shift value one edge back
  assign take   = i_cmd_valid && !o_busy;
  assign wp_bit = i_cmd_data[0];
  // Previous shift content, for the shift direction check
  always_ff @(posedge i_clk) begin
    rx_prev <= o_rx_shift;
  end
  a_preset_mid: assert property (!$past(i_resetn) |-> o_wiper_code == 8'h80)
    else $error("wiper not midscale after reset");
  a_restore_span: assert property (take && i_cmd == wesr_pkg::CMD_RESTORE
    |=> o_busy [*8] ##[1:20] !o_busy)
    else $error("restore length wrong");
  a_store_span: assert property (take && i_cmd == wesr_pkg::CMD_STORE && o_nv_write_ready
    && !o_write_protect |=> o_busy ##1 o_store_busy [*8] ##[1:40] !o_busy)
    else $error("store length wrong");
  a_wiper_hold: assert property (o_busy && $changed(o_wiper_code) |=> !o_busy)
    else $error("wiper moved mid operation");
  a_wiper_write: assert property (take && i_cmd == wesr_pkg::CMD_WR_WIPER && !o_write_protect
    |=> o_wiper_code == $past(i_cmd_data))
    else $error("wiper write lost");
  a_protect_bit: assert property (take && i_cmd == wesr_pkg::CMD_WP
    |=> o_write_protect == $past(wp_bit))
    else $error("protect does not follow bit 0");
  a_early_refuse: assert property (take && i_cmd == wesr_pkg::CMD_WR_NV && !o_nv_write_ready
    |=> o_cmd_refused)
    else $error("early memory write taken");
  a_addr_kept: assert property (o_addr_valid && $past(o_addr_valid) |-> $stable(o_bus_addr))
    else $error("address changed after latch");
  a_addr_base: assert property (o_addr_valid |-> o_bus_addr[6:2] == `WESR_ADDR_BASE)
    else $error("address base wrong");
  a_shift_left: assert property (o_rx_bit |-> o_rx_shift[7:1] == rx_prev[6:0])
    else $error("serial shift wrong");
endmodule
bind wesr_top wesr_monitor u_mon (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_cmd_data(i_cmd_data),
  .o_wiper_code(o_wiper_code), .o_busy(o_busy), .o_store_busy(o_store_busy),
  .o_nv_write_ready(o_nv_write_ready), .o_write_protect(o_write_protect),
  .o_cmd_refused(o_cmd_refused), .o_bus_addr(o_bus_addr), .o_addr_valid(o_addr_valid),
  .o_rx_shift(o_rx_shift), .o_rx_bit(o_rx_bit));
`default_nettype wire

// ---- verif/wesr_top_tb_top.sv ----
// Bench for the wiper sequencer: power-up, commands, store, restore.
// Assumes short timing parameters; serial pins come from the model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %h want %h", $time, a, e); end end
module wesr_top_tb_top;
  localparam int ST = 20; // Store cycles
  localparam int RS = 10; // Restore cycles
  localparam int RW = 40; // Rewrite wait, kept apart from restore end
  logic i_clk = 1'b0, i_resetn = 1'b0, i_sel0 = 1'b0, i_sel1 = 1'b1;
  logic i_cmd_valid = 1'b0, r;
  wesr_pkg::wesr_cmd_t i_cmd = wesr_pkg::CMD_NOP;
  logic [7:0] i_cmd_data = 8'h00, o_wiper_code, o_rx_shift;
  logic [6:0] o_bus_addr;
  logic scl, sda, o_busy, o_store_busy, o_ready, o_wp, o_ref, o_bds, o_av, o_rx_bit;
  int err_total = 0, n_tests = 0, n;
  always #5 i_clk = ~i_clk;
  wesr_i2c_model u_ctl (.o_scl(scl), .o_sda(sda));
  wesr_top #(.STORE_CYC(ST), .RESTORE_CYC(RS), .REWRITE_CYC(RW)) uut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda),
    .i_addr_sel_0(i_sel0), .i_addr_sel_1(i_sel1), .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd), .i_cmd_data(i_cmd_data), .o_wiper_code(o_wiper_code),
    .o_busy(o_busy), .o_store_busy(o_store_busy), .o_nv_write_ready(o_ready),
    .o_write_protect(o_wp), .o_cmd_refused(o_ref), .o_bus_during_store(o_bds),
    .o_bus_addr(o_bus_addr), .o_addr_valid(o_av), .o_rx_shift(o_rx_shift),
    .o_rx_bit(o_rx_bit));
  // Verdict and end of run
  task automatic report_and_stop();
    $display("errors %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait for the end of an operation, cycles counted
  task automatic wait_idle();
    n = 0;
    while (o_busy !== 1'b0) begin
      @(negedge i_clk);
      n++;
      if (n > 500) begin
        err_total++;
        report_and_stop();
      end
    end
  endtask
  // One command pulse; refusal sampled in the cycle after
  task automatic cmd(input wesr_pkg::wesr_cmd_t c, input logic [7:0] d);
    @(negedge i_clk);
    i_cmd_valid = 1'b1;
    i_cmd = c;
    i_cmd_data = d;
    @(negedge i_clk);
    i_cmd_valid = 1'b0;
    r = o_ref;
  endtask
  // Preset, power-on reload, address latch, early memory write
  task automatic t_power_up();
    `CHK(o_wiper_code, 8'h80)
    @(negedge i_clk);
    wait_idle();
    `CHK(n >= RS - 1 && n <= RS + 4, 1'b1)
    `CHK(o_wiper_code, 8'h80)
    `CHK(o_ready, 1'b0)
    cmd(wesr_pkg::CMD_WR_NV, 8'h44);
    `CHK(r, 1'b1)
    `CHK({o_av, o_bus_addr}, {1'b1, 5'h0c, 2'h2})
    i_sel0 = 1'b1;
    for (n = 0; n < 60 && o_ready !== 1'b1; n++) @(negedge i_clk);
    `CHK(o_ready, 1'b1)
    `CHK(o_bus_addr, {5'h0c, 2'h2})
  endtask
  // Memory write then restore; wiper holds until done
  task automatic t_restore();
    cmd(wesr_pkg::CMD_WR_NV, 8'h44);
    wait_idle();
    cmd(wesr_pkg::CMD_WR_WIPER, 8'h11);
    `CHK(o_wiper_code, 8'h11)
    cmd(wesr_pkg::CMD_RESTORE, 8'h00);
    cmd(wesr_pkg::CMD_WR_WIPER, 8'h22);
    `CHK(r, 1'b1)
    `CHK(o_wiper_code, 8'h11)
    wait_idle();
    `CHK(n >= RS - 3 && n <= RS + 4, 1'b1)
    `CHK(o_wiper_code, 8'h44)
  endtask
  // Store with bus traffic during it, then restore of the stored code
  task automatic t_store();
    cmd(wesr_pkg::CMD_WR_WIPER, 8'h5a);
    cmd(wesr_pkg::CMD_STORE, 8'h00);
    fork
      u_ctl.send_byte(8'ha5);
    join_none
    wait_idle();
    `CHK(n >= ST - 3 && n <= ST + 4, 1'b1)
    `CHK(o_bds, 1'b1)
    repeat (120) @(negedge i_clk);
    `CHK(o_rx_shift, 8'ha5)
    cmd(wesr_pkg::CMD_WR_WIPER, 8'h00);
    cmd(wesr_pkg::CMD_RESTORE, 8'h00);
    wait_idle();
    `CHK(o_wiper_code, 8'h5a)
    cmd(wesr_pkg::CMD_NOP, 8'h00);
    `CHK(r, 1'b0)
  endtask
  // Protect on blocks wiper writes; off lets them through
  task automatic t_protect();
    cmd(wesr_pkg::CMD_WP, 8'h01);
    `CHK(o_wp, 1'b1)
    cmd(wesr_pkg::CMD_WR_WIPER, 8'hff);
    `CHK({r, o_wiper_code}, {1'b1, 8'h5a})
    cmd(wesr_pkg::CMD_WP, 8'hfe);
    `CHK(o_wp, 1'b0)
    cmd(wesr_pkg::CMD_WR_WIPER, 8'hff);
    `CHK(o_wiper_code, 8'hff)
  endtask
  // Main sequence
  initial begin
    repeat (8) @(negedge i_clk);
    i_resetn = 1'b1;
    t_power_up();
    t_restore();
    t_store();
    t_protect();
    report_and_stop();
  end
endmodule
`default_nettype wire
